/* File: inc/port_pin_mode_config_defines.vh */
/*
 * Register offsets, field layout, reset values and mode codes for the
 * two-port pin mode and data block.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef PORT_PIN_MODE_CONFIG_DEFINES_VH
`define PORT_PIN_MODE_CONFIG_DEFINES_VH

// ---------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------
`define IDX_PORT4_DATA        8'hc4
`define IDX_PORT5_DATA        8'hc5
`define IDX_PORT4_LOW_CFG     8'hc6
`define IDX_PORT4_HIGH_CFG    8'hc7
`define IDX_PORT5_CFG         8'hc8

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define RST_PORT4_DATA        8'hff
`define RST_PORT5_DATA        4'hf
`define RST_PIN_CFG           8'haa

// ---------------------------------------------------------------------
// Pin mode field codes
// ---------------------------------------------------------------------
`define MODE_W                2
`define MODE_INPUT            2'h0
`define MODE_INPUT_PULLUP     2'h1
`define MODE_OPEN_DRAIN       2'h2
`define MODE_PUSH_PULL        2'h3

`endif

/* File: core/port_pin_mode_config.v */
/*
 * Pin mode and data logic for port four (eight pins) and port five
 * (four pins), reached over a classic Wishbone slave.
 * Assumes pin inputs synchronous to clk; pad pull-ups are enabled by
 * the pull-up outputs; the pad resolves drive from output enables.
 */
// Decided for this implementation: the Wishbone interface to the registers.
//
// Behaviour
// - Port four low config resets to aah
// - Port four low pins selectable input/output
// - Code 00 input, 01 input with pull-up
// - Code 10 open-drain, pull low only
// - Code 11 push-pull, drive both levels
// - Port five config resets to aah
// - Port five pins each independently configurable
// - Port four high config resets to aah
`timescale 1ns/1ps
`include "port_pin_mode_config_defines.vh"

module port_pin_mode_config #(
    parameter P4_PINS = 8,
    parameter P5_PINS = 4
) (
    input  wire                clk,
    input  wire                reset_n,
    input  wire                wb_cyc_i,
    input  wire                wb_stb_i,
    input  wire                wb_we_i,
    input  wire [31:0]         wb_adr_i,
    input  wire [3:0]          wb_sel_i,
    input  wire [31:0]         wb_dat_i,
    output reg  [31:0]         wb_dat_o,
    output reg                 wb_ack_o,
    output wire                wb_err_o,
    input  wire [P4_PINS-1:0]  port4_pin_i,
    output wire [P4_PINS-1:0]  port4_pin_o,
    output wire [P4_PINS-1:0]  port4_pin_oe,
    output wire [P4_PINS-1:0]  port4_pullup_en,
    input  wire [P5_PINS-1:0]  port5_pin_i,
    output wire [P5_PINS-1:0]  port5_pin_o,
    output wire [P5_PINS-1:0]  port5_pin_oe,
    output wire [P5_PINS-1:0]  port5_pullup_en
);

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    reg [7:0]          port4_data_q;
    reg [P5_PINS-1:0]  port5_data_q;
    reg [7:0]          port4_low_pin_config_q;
    reg [7:0]          port4_high_pin_config_q;
    reg [7:0]          port5_pin_config_q;

    wire [15:0]        port4_cfg;
    wire [7:0]         port5_cfg;
    wire               req;
    wire               wr;
    wire               rd_hit;
    wire [29:0]        word_idx;
    reg  [31:0]        rd_d;
    reg                hit_d;
    wire [7:0]         wdata_byte;
    wire [P4_PINS-1:0] port4_rd;
    wire [P5_PINS-1:0] port5_rd;
    wire               sel_port4_data;
    wire               sel_port5_data;
    wire               sel_port4_low_cfg;
    wire               sel_port4_high_cfg;
    wire               sel_port5_cfg;
    wire               wr_port4_data;
    wire               wr_port5_data;
    wire               wr_port4_low_cfg;
    wire               wr_port4_high_cfg;
    wire               wr_port5_cfg;

    // -----------------------------------------------------------------
    // Config views, two bits per pin
    // -----------------------------------------------------------------
    assign port4_cfg = {port4_high_pin_config_q, port4_low_pin_config_q};
    assign port5_cfg = port5_pin_config_q;

    // -----------------------------------------------------------------
    // Wishbone decode
    // -----------------------------------------------------------------
    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign word_idx = wb_adr_i[31:2];
    assign wr       = req & wb_we_i & wb_sel_i[0] & hit_d;
    assign rd_hit   = hit_d;
    assign wb_err_o = 1'b0;
    assign wdata_byte = wb_dat_i[7:0];

    // -----------------------------------------------------------------
    // Register select, one per mapped word
    // -----------------------------------------------------------------
    assign sel_port4_data     = (word_idx == {22'h0, `IDX_PORT4_DATA});
    assign sel_port5_data     = (word_idx == {22'h0, `IDX_PORT5_DATA});
    assign sel_port4_low_cfg  = (word_idx == {22'h0, `IDX_PORT4_LOW_CFG});
    assign sel_port4_high_cfg = (word_idx == {22'h0, `IDX_PORT4_HIGH_CFG});
    assign sel_port5_cfg      = (word_idx == {22'h0, `IDX_PORT5_CFG});

    // -----------------------------------------------------------------
    // Write strobes; only the low byte lane carries data
    // -----------------------------------------------------------------
    assign wr_port4_data      = wr & sel_port4_data;
    assign wr_port5_data      = wr & sel_port5_data;
    assign wr_port4_low_cfg   = wr & sel_port4_low_cfg;
    assign wr_port4_high_cfg  = wr & sel_port4_high_cfg;
    assign wr_port5_cfg       = wr & sel_port5_cfg;

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    always @* begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        case (word_idx)
            {22'h0, `IDX_PORT4_DATA}: begin
                rd_d[P4_PINS-1:0] = port4_rd;
            end
            {22'h0, `IDX_PORT5_DATA}: begin
                rd_d[P5_PINS-1:0] = port5_rd;
            end
            {22'h0, `IDX_PORT4_LOW_CFG}: begin
                rd_d[7:0] = port4_low_pin_config_q;
            end
            {22'h0, `IDX_PORT4_HIGH_CFG}: begin
                rd_d[7:0] = port4_high_pin_config_q;
            end
            {22'h0, `IDX_PORT5_CFG}: begin
                rd_d[7:0] = port5_pin_config_q;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Bus answer: ack one cycle after the request is taken
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // -----------------------------------------------------------------
    // Read data register; zero outside the ack cycle and when unmapped
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i && rd_hit) begin
            wb_dat_o <= rd_d;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // -----------------------------------------------------------------
    // Register writes
    // -----------------------------------------------------------------
    // Port four data latch
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port4_data_q <= `RST_PORT4_DATA;
        end else if (wr_port4_data) begin
            port4_data_q <= wdata_byte;
        end
    end

    // Port five data latch, low lane only
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port5_data_q <= `RST_PORT5_DATA;
        end else if (wr_port5_data) begin
            port5_data_q <= wdata_byte[P5_PINS-1:0];
        end
    end

    // Port four low pin modes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port4_low_pin_config_q <= `RST_PIN_CFG;
        end else if (wr_port4_low_cfg) begin
            port4_low_pin_config_q <= wdata_byte;
        end
    end

    // Port four high pin modes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port4_high_pin_config_q <= `RST_PIN_CFG;
        end else if (wr_port4_high_cfg) begin
            port4_high_pin_config_q <= wdata_byte;
        end
    end

    // Port five pin modes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port5_pin_config_q <= `RST_PIN_CFG;
        end else if (wr_port5_cfg) begin
            port5_pin_config_q <= wdata_byte;
        end
    end

    // -----------------------------------------------------------------
    // Pad control per pin
    // -----------------------------------------------------------------
    genvar g;
    generate
        // Port four, one pin slice per pin
        for (g = 0; g < P4_PINS; g = g + 1) begin : g_p4
            port_pin_pad #(
                .MODE_W    (`MODE_W)
            ) u_port_pin_pad (
                .mode      (port4_cfg[2*g+1:2*g]),
                .latch     (port4_data_q[g]),
                .pin_i     (port4_pin_i[g]),
                .pin_o     (port4_pin_o[g]),
                .pin_oe    (port4_pin_oe[g]),
                .pullup_en (port4_pullup_en[g]),
                .rd_bit    (port4_rd[g])
            );
        end

        // Port five, one pin slice per pin
        for (g = 0; g < P5_PINS; g = g + 1) begin : g_p5
            port_pin_pad #(
                .MODE_W    (`MODE_W)
            ) u_port_pin_pad (
                .mode      (port5_cfg[2*g+1:2*g]),
                .latch     (port5_data_q[g]),
                .pin_i     (port5_pin_i[g]),
                .pin_o     (port5_pin_o[g]),
                .pin_oe    (port5_pin_oe[g]),
                .pullup_en (port5_pullup_en[g]),
                .rd_bit    (port5_rd[g])
            );
        end
    endgenerate

endmodule // port_pin_mode_config

// ---------------------------------------------------------------------
// One pin: mode decode, pad drive and read-back bit
// ---------------------------------------------------------------------
module port_pin_pad #(
    parameter MODE_W = `MODE_W
) (
    // Register side
    input  wire [MODE_W-1:0]   mode,
    input  wire                latch,
    // Pad side; rd_bit feeds the register read-back
    input  wire                pin_i,
    output reg                 pin_o,
    output reg                 pin_oe,
    output reg                 pullup_en,
    output reg                 rd_bit
);

    // -----------------------------------------------------------------
    // Mode decode
    // -----------------------------------------------------------------
    always @* begin
        pin_o     = 1'b0;
        pin_oe    = 1'b0;
        pullup_en = 1'b0;
        rd_bit    = pin_i;
        case (mode)
            // Pad released, level read back
            `MODE_INPUT: begin
                rd_bit = pin_i;
            end
            // Pull-up on, pad still released
            `MODE_INPUT_PULLUP: begin
                pullup_en = 1'b1;
            end
            // Sink only; a high latch leaves the pin released
            `MODE_OPEN_DRAIN: begin
                pin_oe = ~latch;
                rd_bit = latch;
            end
            // Both levels driven from the latch
            `MODE_PUSH_PULL: begin
                pin_o  = latch;
                pin_oe = 1'b1;
                rd_bit = latch;
            end
            default: begin
                rd_bit = pin_i;
            end
        endcase
    end

endmodule // port_pin_pad

/* File: dv/port_pin_mode_config_checker.sv */
/* Port block checker; bound to the block top below. */
`timescale 1ns/1ps
module port_pin_mode_config_checker #(parameter P4_PINS = 8, P5_PINS = 4) (
    input wire logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [P4_PINS-1:0] port4_pin_oe, port4_pullup_en,
    input wire logic [P5_PINS-1:0] port5_pin_oe, port5_pullup_en
);
    wire [2*(P4_PINS+P5_PINS)-1:0] pins = {port4_pin_oe, port5_pin_oe,
        port4_pullup_en, port5_pullup_en};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_pulse: assert property (s_req |=> s_pulse)
        else $error("ack not one pulse");
    a_ack_cause: assert property (wb_ack_o |->
        $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    a_err_quiet: assert property (!wb_err_o)
        else $error("err raised");
    a_dat_idle: assert property (!wb_ack_o |-> !wb_dat_o)
        else $error("data outside ack");
    a_dat_upper: assert property (wb_ack_o |-> !wb_dat_o[31:8])
        else $error("upper data set");
    a_pull_float: assert property (
        !(port4_pullup_en & port4_pin_oe) && !(port5_pullup_en & port5_pin_oe))
        else $error("pull-up while driving");
    a_reset_state: assert property ($rose(reset_n) |-> !pins)
        else $error("pins active after reset");
    a_pins_on_write: assert property (!$stable(pins) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i)) else $error("pins moved");
endmodule // port_pin_mode_config_checker
bind port_pin_mode_config port_pin_mode_config_checker #(
    .P4_PINS(P4_PINS), .P5_PINS(P5_PINS)) u_chk (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o),
    .port4_pin_oe(port4_pin_oe), .port4_pullup_en(port4_pullup_en),
    .port5_pin_oe(port5_pin_oe), .port5_pullup_en(port5_pullup_en));

/* File: dv/port_pads.sv */
/* Board pads: level from drive, external source or pull-up. */
`timescale 1ns/1ps
module port_pads #(parameter N = 12) (
    input wire logic         clk, ext_en,
    input wire logic [N-1:0] pin_o, oe, pu, ext_v,
    output logic     [N-1:0] lvl
);
    logic tog = 1'b0;
    // Floating pins wander so no stale level is read
    always @(posedge clk) tog <= ~tog;
    always_comb for (int i = 0; i < N; i++)
        lvl[i] = oe[i] ? pin_o[i] : ext_en ? ext_v[i] : pu[i] | tog;
endmodule // port_pads

/* File: dv/port_pin_mode_config_test.sv */
/* Port block bench; pads stand for the board. */
`timescale 1ns/1ps
module port_pin_mode_config_test;
    logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, ext = 0, ack;
    logic [31:0] adr = 0, wd = 0, rd;
    logic [7:0] o4, oe4, pu4, i4, q;
    logic [3:0] o5, oe5, pu5, i5, e_oe, e_pu, e_rd;
    logic [7:0] rst_v [6] = '{8'hff, 8'h0f, 8'haa, 8'haa, 8'haa, 8'h00};
    int n_mismatch = 0, n_tests = 0;
    initial forever #2 clk = ~clk;
    port_pin_mode_config u_port_pin_mode_config (.clk(clk),
        .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack), .wb_err_o(), .port4_pin_i(i4), .port4_pin_o(o4),
        .port4_pin_oe(oe4), .port4_pullup_en(pu4), .port5_pin_i(i5),
        .port5_pin_o(o5), .port5_pin_oe(oe5), .port5_pullup_en(pu5));
    port_pads u_pads (.clk(clk), .pin_o({o4, o5}), .oe({oe4, oe5}),
        .pu({pu4, pu5}), .ext_v(12'h3cc), .ext_en(ext), .lvl({i4, i5}));
    task automatic chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input logic [31:0] a, input logic w, [7:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= a;
        wd <= {24'h0, d};
        for (k = 0; k < 50 && ack !== 1'b1; k++) @(posedge clk);
        if (ack !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
        q = rd[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1;
        for (int i = 0; i < 6; i++) begin
            bus(32'h310 + 4 * i, 0, 0);
            chk(q, rst_v[i]);
        end
        $display("reset test done");
        bus(32'h310, 1, 8'h5a);
        bus(32'h314, 1, 8'h0a);
        for (int m = 0; m < 4; m++) begin
            e_oe = (m == 2) ? 4'h5 : (m == 3) ? 4'hf : 4'h0;
            e_pu = (m == 1) ? 4'hf : 4'h0;
            e_rd = (m > 1) ? 4'ha : (m == 1) ? 4'hf : 4'hc;
            ext <= (m == 0);
            bus(32'h318, 1, {4{m[1:0]}});
            bus(32'h320, 1, {4{m[1:0]}});
            bus(32'h310, 0, 0);
            chk(q, {4'h5, e_rd});
            bus(32'h314, 0, 0);
            chk(q, {4'h0, e_rd});
            chk({oe4[3:0], oe5}, {2{e_oe}});
            chk({pu4[3:0], pu5}, {2{e_pu}});
            chk({o4[3:0] & oe4[3:0], o5 & oe5}, {2{e_oe & 4'ha}});
            $display("mode %0d test done", m);
        end
        bus(32'h320, 1, 8'he4);
        bus(32'h31c, 1, 8'hff);
        @(posedge clk);
        chk({oe5, pu5}, 8'hc2);
        chk({oe4[7:4], o4[7:4]}, 8'hf5);
        $display("mixed test done");
        close_out;
    end
endmodule // port_pin_mode_config_test
